// File: src/memory_type_range_map.sv
// memory type range map: default, fixed and variable ranges with type lookup
// assumes a privileged register write/read port and a core address lookup port, one clock
`timescale 1ns/10ps

module memory_type_range_map #(
  parameter int phys_addr_width = mem_type_pkg::addr_w_default
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_sel,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_fault,
  input wire logic [phys_addr_width-1:0] lookup_addr,
  output logic [7:0] lookup_type
);
  localparam int field_w = phys_addr_width - mem_type_pkg::page_shift;
  // eight type bytes per fixed register, so three address bits pick the byte
  localparam int lanes = mem_type_pkg::data_w / mem_type_pkg::type_w;
  localparam int lane_sel_w = $clog2(lanes);
  // address bit that picks the upper 16K register of the pair
  localparam int reg16_bit = mem_type_pkg::span_16k_shift + lane_sel_w;
  // lowest address bit and width of the 4K register index
  localparam int reg4_lsb = mem_type_pkg::span_4k_shift + lane_sel_w;
  localparam int reg4_sel_w = $clog2(mem_type_pkg::fixed_regs - mem_type_pkg::fixed_4k_reg0);
  // select layout of the pairs: base/mask bit at the bottom, pair index above
  localparam int sel_mask_bit = 0;
  localparam int sel_pair_lsb = 1;
  localparam int sel_pair_w = $clog2(mem_type_pkg::var_pairs);

  typedef enum logic [1:0] {
    grp_default = 2'b00,
    grp_fixed = 2'b01,
    grp_var = 2'b10,
    grp_none = 2'b11
  } reg_group_t;

  // register state
  logic [7:0] def_type_q, def_type_d;
  logic fixed_map_on_q, fixed_map_on_d;
  logic global_switch_q, global_switch_d;
  logic [63:0] fixed_q [mem_type_pkg::fixed_regs];
  logic [63:0] fixed_d [mem_type_pkg::fixed_regs];
  logic [field_w-1:0] base_q [mem_type_pkg::var_pairs];
  logic [field_w-1:0] base_d [mem_type_pkg::var_pairs];
  logic [7:0] vtype_q [mem_type_pkg::var_pairs];
  logic [7:0] vtype_d [mem_type_pkg::var_pairs];
  logic [field_w-1:0] mask_q [mem_type_pkg::var_pairs];
  logic [field_w-1:0] mask_d [mem_type_pkg::var_pairs];
  logic in_use_q [mem_type_pkg::var_pairs];
  logic in_use_d [mem_type_pkg::var_pairs];
  logic [63:0] rdata_d;
  logic fault_d;

  reg_group_t grp;
  logic [3:0] fix_idx;
  logic [2:0] pair_idx;
  logic is_mask;
  logic types_legal;
  logic def_legal;
  logic [63:0] def_resv_mask;
  logic [63:0] base_resv_mask;
  logic [63:0] mask_resv_mask;
  logic write_ok;

  // decode the register select
  // selects between the fixed and the variable groups stay unmapped and fault
  always_comb begin
    grp = grp_none;
    fix_idx = 4'h0;
    pair_idx = reg_sel[sel_pair_lsb +: sel_pair_w];
    is_mask = reg_sel[sel_mask_bit];
    if (reg_sel == mem_type_pkg::sel_default_type) begin
      grp = grp_default;
    end else if (reg_sel >= mem_type_pkg::sel_fixed_first && reg_sel <= mem_type_pkg::sel_fixed_last) begin
      grp = grp_fixed;
      fix_idx = 4'(reg_sel - mem_type_pkg::sel_fixed_first);
    end else if (reg_sel >= mem_type_pkg::sel_var_first && reg_sel <= mem_type_pkg::sel_var_last) begin
      grp = grp_var;
    end
  end

  // byte-lane legality of the written type fields
  type_field_check #(
    .fields(lanes)
  ) u_check (
    .value(reg_wdata),
    .all_legal(types_legal)
  );

  // reserved bit masks: ones mark bits that must be written as zero
  always_comb begin
    def_resv_mask = ~64'h0;
    def_resv_mask[mem_type_pkg::type_w-1:0] = '0;
    def_resv_mask[mem_type_pkg::fixed_map_on_bit] = 1'b0;
    def_resv_mask[mem_type_pkg::global_switch_bit] = 1'b0;
    base_resv_mask = ~64'h0;
    base_resv_mask[mem_type_pkg::type_w-1:0] = '0;
    base_resv_mask[phys_addr_width-1:mem_type_pkg::page_shift] = '0;
    mask_resv_mask = ~64'h0;
    mask_resv_mask[mem_type_pkg::pair_in_use_bit] = 1'b0;
    mask_resv_mask[phys_addr_width-1:mem_type_pkg::page_shift] = '0;
  end

  // only the low byte needs checking for the default and base registers
  type_field_check #(
    .fields(1)
  ) u_check_low (
    .value(reg_wdata[7:0]),
    .all_legal(def_legal)
  );

  // a write either completes or faults
  // a faulting write leaves every register untouched
  always_comb begin
    write_ok = 1'b0;
    unique case (grp)
      grp_default: begin
        write_ok = def_legal && ((reg_wdata & def_resv_mask) == 64'h0);
      end
      grp_fixed: begin
        write_ok = types_legal;
      end
      grp_var: begin
        if (is_mask) begin
          write_ok = (reg_wdata & mask_resv_mask) == 64'h0;
        end else begin
          write_ok = def_legal && ((reg_wdata & base_resv_mask) == 64'h0);
        end
      end
      grp_none: begin
        write_ok = 1'b0;
      end
    endcase
  end

  // next register values and read data
  // reads of unmapped selects fault and return zero
  always_comb begin
    def_type_d = def_type_q;
    fixed_map_on_d = fixed_map_on_q;
    global_switch_d = global_switch_q;
    fixed_d = fixed_q;
    base_d = base_q;
    vtype_d = vtype_q;
    mask_d = mask_q;
    in_use_d = in_use_q;
    rdata_d = 64'h0;
    fault_d = 1'b0;
    if (reg_wr) begin
      fault_d = !write_ok;
      if (write_ok) begin
        unique case (grp)
          grp_default: begin
            def_type_d = reg_wdata[7:0];
            fixed_map_on_d = reg_wdata[mem_type_pkg::fixed_map_on_bit];
            global_switch_d = reg_wdata[mem_type_pkg::global_switch_bit];
          end
          grp_fixed: begin
            fixed_d[fix_idx] = reg_wdata;
          end
          grp_var: begin
            if (is_mask) begin
              mask_d[pair_idx] = reg_wdata[phys_addr_width-1:mem_type_pkg::page_shift];
              in_use_d[pair_idx] = reg_wdata[mem_type_pkg::pair_in_use_bit];
            end else begin
              base_d[pair_idx] = reg_wdata[phys_addr_width-1:mem_type_pkg::page_shift];
              vtype_d[pair_idx] = reg_wdata[7:0];
            end
          end
          grp_none: begin
          end
        endcase
      end
    end else if (reg_rd) begin
      unique case (grp)
        grp_default: begin
          rdata_d[7:0] = def_type_q;
          rdata_d[mem_type_pkg::fixed_map_on_bit] = fixed_map_on_q;
          rdata_d[mem_type_pkg::global_switch_bit] = global_switch_q;
        end
        grp_fixed: begin
          rdata_d = fixed_q[fix_idx];
        end
        grp_var: begin
          if (is_mask) begin
            rdata_d[phys_addr_width-1:mem_type_pkg::page_shift] = mask_q[pair_idx];
            rdata_d[mem_type_pkg::pair_in_use_bit] = in_use_q[pair_idx];
          end else begin
            rdata_d[phys_addr_width-1:mem_type_pkg::page_shift] = base_q[pair_idx];
            rdata_d[7:0] = vtype_q[pair_idx];
          end
        end
        grp_none: begin
          fault_d = 1'b1;
        end
      endcase
    end
  end

  // register stage; only the global switch, the in-use bits, read data and fault are reset, the rest keep undefined contents
  // software must program every field before it sets the global switch;
  // until then lookup answers no_caching and never sees the stale contents
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_switch_q <= 1'b0;
      in_use_q <= '{default: 1'b0};
      reg_rdata <= 64'h0;
      reg_fault <= 1'b0;
    end else begin
      global_switch_q <= global_switch_d;
      in_use_q <= in_use_d;
      reg_rdata <= rdata_d;
      reg_fault <= fault_d;
    end
    def_type_q <= def_type_d;
    fixed_map_on_q <= fixed_map_on_d;
    fixed_q <= fixed_d;
    base_q <= base_d;
    vtype_q <= vtype_d;
    mask_q <= mask_d;
  end

  // per-pair match against the masked base
  // a pair not in use is gated first, so its undefined fields never matter
  logic [mem_type_pkg::var_pairs-1:0] hit;
  genvar p;
  generate
    for (p = 0; p < mem_type_pkg::var_pairs; p++) begin : g_pair
      assign hit[p] = in_use_q[p] &&
        ((lookup_addr[phys_addr_width-1:mem_type_pkg::page_shift] & mask_q[p]) ==
         (base_q[p] & mask_q[p]));
    end
  endgenerate

  // fixed range selection within the first megabyte
  // addresses at or above one megabyte never reach the fixed table,
  // so the byte picked here is only used when in_first_mb is set
  logic in_first_mb;
  logic [3:0] f_reg;
  logic [2:0] f_byte;
  logic [19:0] low_addr;
  logic [7:0] fixed_type;

  always_comb begin
    low_addr = lookup_addr[mem_type_pkg::first_mb_shift-1:0];
    in_first_mb = (lookup_addr >> mem_type_pkg::first_mb_shift) == '0;
    if (low_addr < mem_type_pkg::fixed_16k_start) begin
      f_reg = 4'h0;
      f_byte = low_addr[mem_type_pkg::span_64k_shift +: lane_sel_w];
    end else if (low_addr < mem_type_pkg::fixed_4k_start) begin
      f_reg = 4'(mem_type_pkg::fixed_16k_reg0 + int'(low_addr[reg16_bit]));
      f_byte = low_addr[mem_type_pkg::span_16k_shift +: lane_sel_w];
    end else begin
      f_reg = 4'(mem_type_pkg::fixed_4k_reg0 + int'(low_addr[reg4_lsb +: reg4_sel_w]));
      f_byte = low_addr[mem_type_pkg::span_4k_shift +: lane_sel_w];
    end
    fixed_type = fixed_q[f_reg][f_byte*mem_type_pkg::type_w +: mem_type_pkg::type_w];
  end

  // combine matching variable pairs
  // pairs are scanned from zero, so first_type is the lowest matching pair
  logic any_hit;
  logic any_uc;
  logic any_wt;
  logic all_same;
  logic [7:0] first_type;

  always_comb begin
    any_hit = 1'b0;
    any_uc = 1'b0;
    any_wt = 1'b0;
    all_same = 1'b1;
    first_type = mem_type_pkg::type_no_caching;
    for (int i = 0; i < mem_type_pkg::var_pairs; i++) begin
      if (hit[i]) begin
        if (!any_hit) begin
          first_type = vtype_q[i];
        end else if (vtype_q[i] != first_type) begin
          all_same = 1'b0;
        end
        any_hit = 1'b1;
        any_uc = any_uc | (vtype_q[i] == mem_type_pkg::type_no_caching);
        any_wt = any_wt | (vtype_q[i] == mem_type_pkg::type_write_through);
      end
    end
  end

  // final precedence, answered in the same cycle
  // global switch off wins over everything, fixed enable included;
  // then the fixed table inside the first megabyte, then the pairs;
  // overlaps with no defined outcome fall back to the lowest pair
  always_comb begin
    if (!global_switch_q) begin
      lookup_type = mem_type_pkg::type_no_caching;
    end else if (fixed_map_on_q && in_first_mb) begin
      lookup_type = fixed_type;
    end else if (any_hit) begin
      if (any_uc) begin
        lookup_type = mem_type_pkg::type_no_caching;
      end else if (all_same) begin
        lookup_type = first_type;
      end else if (any_wt) begin
        lookup_type = mem_type_pkg::type_write_through;
      end else begin
        lookup_type = first_type;
      end
    end else begin
      lookup_type = def_type_q;
    end
  end
endmodule

// File: src/mem_type_pkg.sv
// constants for the memory type range map: register selects, field layout, encodings
// assumes a 64-bit register write port driven by privileged software
package mem_type_pkg;
  localparam int data_w = 64;
  localparam int type_w = 8;
  localparam int fixed_regs = 11;
  localparam int var_pairs = 8;
  localparam int addr_w_default = 36;
  // register select codes on the register port
  localparam logic [4:0] sel_default_type = 5'h00;
  localparam logic [4:0] sel_fixed_first = 5'h01;
  localparam logic [4:0] sel_fixed_last = 5'h0b;
  localparam logic [4:0] sel_var_first = 5'h10;
  localparam logic [4:0] sel_var_last = 5'h1f;
  // default-type register layout
  localparam int fixed_map_on_bit = 10;
  localparam int global_switch_bit = 11;
  // variable pair layout
  localparam int pair_in_use_bit = 11;
  localparam int page_shift = 12;
  // fixed range windows
  localparam int span_64k_shift = 16;
  localparam int span_16k_shift = 14;
  localparam int span_4k_shift = 12;
  localparam logic [19:0] fixed_16k_start = 20'h80000;
  localparam logic [19:0] fixed_4k_start = 20'hc0000;
  localparam int fixed_16k_reg0 = 1;
  localparam int fixed_4k_reg0 = 3;
  localparam int first_mb_shift = 20;
  // memory type encodings
  localparam logic [7:0] type_no_caching = 8'h00;
  localparam logic [7:0] type_write_combining = 8'h01;
  localparam logic [7:0] type_write_through = 8'h04;
  localparam logic [7:0] type_write_protected = 8'h05;
  localparam logic [7:0] type_write_back = 8'h06;
endpackage

// File: src/type_field_check.sv
// legality checker for memory type encodings, one per byte of a register
// assumes nothing beyond combinational inputs
`timescale 1ns/10ps
module type_field_check #(
  parameter int fields = 8
) (
  input wire logic [fields*8-1:0] value,
  output logic all_legal
);
  logic [fields-1:0] ok;

  // one checker per byte lane
  genvar g;
  generate
    for (g = 0; g < fields; g++) begin : g_lane
      logic [7:0] t;
      assign t = value[g*8 +: 8];
      assign ok[g] = (t == mem_type_pkg::type_no_caching) || (t == mem_type_pkg::type_write_combining) ||
                     (t == mem_type_pkg::type_write_through) || (t == mem_type_pkg::type_write_protected) ||
                     (t == mem_type_pkg::type_write_back);
    end
  endgenerate

  assign all_legal = &ok;
endmodule

// File: test/type_map_sva.sv
// checker for the memory type range map ports
// assumes binding to the top module, one clock, sync reset
`timescale 1ns/10ps
module type_map_sva #(
  parameter int phys_addr_width = 36
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_sel,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_fault,
  input wire logic [phys_addr_width-1:0] lookup_addr,
  input wire logic [7:0] lookup_type
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic glob_q, glob_d, pend_q, pend_d, pbit_q, pbit_d;
  function automatic logic bad(input logic [7:0] t);
    return !(t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06});
  endfunction
  function automatic logic any_bad(input logic [63:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) r |= bad(v[i*8 +: 8]);
    return r;
  endfunction
  // follow the global switch through accepted default-type writes
  always_comb begin
    pend_d = rst_n && reg_wr && reg_sel == 5'h00;
    pbit_d = reg_wdata[11];
    glob_d = (pend_q && !reg_fault) ? pbit_q : glob_q;
    if (!rst_n) glob_d = 1'b0;
  end
  always_ff @(posedge clk) begin
    glob_q <= glob_d;
    pend_q <= pend_d;
    pbit_q <= pbit_d;
  end
  sequence s_def_wr; reg_wr && reg_sel == 5'h00; endsequence
  sequence s_fix_wr; reg_wr && reg_sel inside {[5'h01:5'h0b]}; endsequence
  sequence s_var_wr; reg_wr && reg_sel[4]; endsequence
  AST_RESET_IDLE: assert property ($rose(rst_n) |-> !reg_fault && reg_rdata == 64'h0)
    else $error("outputs not idle after reset");
  AST_GLOBAL_OFF: assert property (!glob_q && !pend_q |-> lookup_type == 8'h00)
    else $error("type not no_caching while switched off");
  AST_DEF_TYPE: assert property (s_def_wr ##0 bad(reg_wdata[7:0]) |=> reg_fault)
    else $error("illegal default type accepted");
  AST_DEF_RSVD: assert property (s_def_wr ##0 (reg_wdata[9:8] != 2'h0 || reg_wdata[63:12] != 52'h0) |=> reg_fault)
    else $error("reserved default bits accepted");
  AST_DEF_OK: assert property (s_def_wr ##0 (reg_wdata[63:12] == 52'h0
    && reg_wdata[9:8] == 2'h0 && !bad(reg_wdata[7:0])) |=> !reg_fault)
    else $error("legal default write refused");
  AST_FIX_TYPE: assert property (s_fix_wr ##0 any_bad(reg_wdata) |=> reg_fault)
    else $error("illegal fixed type accepted");
  AST_VAR_TYPE: assert property (s_var_wr ##0 (!reg_sel[0] && bad(reg_wdata[7:0])) |=> reg_fault)
    else $error("illegal pair type accepted");
  AST_VAR_RSVD: assert property (s_var_wr ##0 ((reg_wdata >> phys_addr_width) != 64'h0
    || (reg_sel[0] ? reg_wdata[10:0] != 11'h0 : reg_wdata[11:8] != 4'h0)) |=> reg_fault)
    else $error("reserved pair bits accepted");
  AST_UNMAPPED: assert property (reg_rd && !reg_wr && reg_sel inside {[5'h0c:5'h0f]}
    |=> reg_fault && reg_rdata == 64'h0)
    else $error("unmapped read not refused");
endmodule

// File: test/core_addr_model.sv
// core address path: presents addresses and samples the resolved type
// assumes the lookup answers within the same cycle
`timescale 1ns/10ps
module core_addr_model #(
  parameter int aw = 36
) (
  input wire logic clk,
  output logic [aw-1:0] lookup_addr,
  input wire logic [7:0] lookup_type
);
  initial lookup_addr = '0;
  // drive after the falling edge, sample once settled
  task automatic fetch(input logic [aw-1:0] a, output logic [7:0] t);
    @(negedge clk);
    lookup_addr = a;
    #10;
    t = lookup_type;
  endtask
endmodule

// File: test/memory_type_range_map_tb_top.sv
// testbench for the memory type range map
// assumes the core model and the bound checker
`timescale 1ns/10ps
module memory_type_range_map_tb_top;
  localparam int aw = 36;
  logic clk, rst_n, reg_wr, reg_rd, reg_fault;
  logic [4:0] reg_sel;
  logic [63:0] reg_wdata, reg_rdata, v;
  logic [aw-1:0] lookup_addr;
  logic [7:0] lookup_type;
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  logic [7:0] bad_codes [4] = '{8'h02, 8'h03, 8'h07, 8'hff};
  logic [63:0] rsv [4] = '{64'h906, 64'ha06, 64'h1806, 64'h8000_0000_0000_0806};
  logic [63:0] pb [6] = '{64'h6, 64'h0100_0004, 64'h0180_0000, 64'h6, 64'h1000_0001, 64'h4000_0005};
  logic [63:0] pm [6] = '{64'hf_fc00_0800, 64'hf_ff00_0800, 64'hf_ff80_0800, 64'hf_f000_0800,
    64'hf_f000_0000, 64'hf_e010_0800};
  logic [aw-1:0] la [8] = '{36'h200_0000, 36'h1000_0000, 36'h100_0000, 36'h180_0000, 36'h0,
    36'h4000_0000, 36'h4010_0000, 36'h4020_0000};
  logic [7:0] le [8] = '{8'h06, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h05};
  int num_errors = 0;
  int checks_done = 0;
  memory_type_range_map #(.phys_addr_width(aw)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_fault(reg_fault), .lookup_addr(lookup_addr), .lookup_type(lookup_type));
  core_addr_model #(.aw(aw)) core (.clk(clk), .lookup_addr(lookup_addr), .lookup_type(lookup_type));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] s, input logic [63:0] d, input logic f);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    chk("fault", {63'h0, f}, {63'h0, reg_fault});
  endtask
  task automatic rd(input logic [4:0] s, input logic [63:0] e, input logic [63:0] m, input logic f);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_sel = s;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("fault", {63'h0, f}, {63'h0, reg_fault});
    chk("rdata", e & m, reg_rdata & m);
  endtask
  task automatic look(input logic [aw-1:0] a, input logic [7:0] e);
    logic [7:0] t;
    core.fetch(a, t);
    chk("type", {56'h0, e}, {56'h0, t});
  endtask
  // last address of fixed field j in fixed register i
  function automatic logic [aw-1:0] fix_addr(input int i, input int j);
    if (i == 0) return aw'((j << 16) + 32'hffff);
    if (i < 3) return aw'(32'h80000 + (((i - 1) * 8 + j) << 14) + 32'h3fff);
    return aw'(32'hc0000 + (((i - 3) * 8 + j) << 12) + 32'hfff);
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 5'h00;
    reg_wdata = 64'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    look(36'h0, 8'h00);
    rd(5'h00, 64'h0, 64'h800, 1'b0);
    for (int n = 0; n < 8; n++) rd(5'h11 + 5'(2 * n), 64'h0, 64'h800, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(5'h00, 64'h800 | codes[i], 1'b0);
      look(36'h1000_0000, codes[i]);
    end
    foreach (bad_codes[k]) wr(5'h00, 64'h800 | bad_codes[k], 1'b1);
    foreach (rsv[k]) wr(5'h00, rsv[k], 1'b1);
    rd(5'h00, 64'h806, '1, 1'b0);
    // fixed registers: the five legal codes in rotation across the fields
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 8; j++) v[j*8 +: 8] = codes[(i + j) % 5];
      wr(5'h01 + 5'(i), v, 1'b0);
      rd(5'h01 + 5'(i), v, '1, 1'b0);
    end
    wr(5'h01, 64'h200, 1'b1);
    wr(5'h00, 64'hc06, 1'b0);
    for (int i = 0; i < 11; i++)
      for (int j = 0; j < 8; j++) look(fix_addr(i, j), codes[(i + j) % 5]);
    look(36'h10_0000, 8'h06);
    wr(5'h00, 64'h806, 1'b0);
    look(36'h0, 8'h06);
    wr(5'h00, 64'h406, 1'b0);
    look(36'h0, 8'h00);
    // variable pairs over a no_caching default with fixed ranges on
    wr(5'h00, 64'hc00, 1'b0);
    for (int p = 0; p < 6; p++) begin
      wr(5'h10 + 5'(2 * p), pb[p], 1'b0);
      wr(5'h11 + 5'(2 * p), pm[p], 1'b0);
      rd(5'h10 + 5'(2 * p), pb[p], '1, 1'b0);
      rd(5'h11 + 5'(2 * p), pm[p], '1, 1'b0);
    end
    for (int k = 0; k < 8; k++) look(la[k], le[k]);
    wr(5'h00, 64'h800, 1'b0);
    look(36'h0, 8'h06);
    wr(5'h19, 64'hf_f000_0800, 1'b0);
    look(36'h1000_0000, 8'h01);
    wr(5'h10, 64'h206, 1'b1);
    wr(5'h11, 64'h10_0000_0800, 1'b1);
    wr(5'h11, 64'hf_f000_0801, 1'b1);
    wr(5'h12, 64'h3, 1'b1);
    look(36'h100_0000, 8'h04);
    // reset in mid-run: global switch and in-use bits drop, lookup falls back to no_caching
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rd(5'h11, 64'h0, 64'h800, 1'b0);
    rd(5'h00, 64'h0, 64'h800, 1'b0);
    look(36'h200_0000, 8'h00);
    wr(5'h0c, 64'h0, 1'b1);
    rd(5'h0e, 64'h0, '1, 1'b1);
    give_verdict();
  end
endmodule
bind memory_type_range_map type_map_sva #(.phys_addr_width(phys_addr_width)) u_sva (.clk(clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_fault(reg_fault), .lookup_addr(lookup_addr), .lookup_type(lookup_type));
